// ===== bench/sample_ram.sv
// Halfword RAM model that takes the writes of the sample DMA.
// Assumes byte addresses with bit 0 at zero and one write per cycle, never stalled.
`timescale 1ns/1ns
`default_nettype none

module sample_ram
   import adc_ctrl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire ram_write_s ram_write
);

   logic [15:0] mem [0:4095];

   // The RAM never stalls, so a write lands on the edge that carries it.
   always_ff @(posedge ref_clk)
   begin
      if (ram_write.write_en === 1'b1)
      begin
         mem[ram_write.addr[12:1]] <= ram_write.data;
      end
   end

endmodule

`default_nettype wire

// ===== bench/test_adc_control_and_sample_dma.sv
// Self-checking bench for the converter control block and its sample DMA.
// Assumes the design files, the register map header and the sample RAM model.
`include "adc_ctrl_map.svh"
`timescale 1ns/1ns
`default_nettype none

module test_adc_control_and_sample_dma
   import adc_ctrl_pkg::*;
;

   logic        ref_clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq_request;
   logic        conv_clk_en, conv_sample, raw_valid, rd_phase, sat_exp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] raw_result, offs, gain;
   logic [31:0] haddr, hwdata, hrdata, cfg;
   logic [28:0] wq [$];
   logic [31:0] rq [$];
   config_s     conv_config;
   ram_write_s  ram_write;
   int          bad_count, compares, cyc, i;
   logic [15:0] ofs [11] = '{`OFS_DMA_COUNT, `OFS_EVENT_FLAGS, `OFS_EVENT_ENABLES, `OFS_CONFIG,
      `OFS_OFFSET, `OFS_GAIN, `OFS_DMA_CONTROL, `OFS_DMA_STATE, `OFS_BUF_START,
      `OFS_BUF_LENGTH, `OFS_NEXT_ADDR};
   logic [31:0] rst [11] = '{0, 0, 0, 32'h1800, 0, 32'h8000, 0, 0, 32'h2000_0000, 0,
      32'h2000_0000};

   adc_ctrl #(.STARTUP_CYCLES(4)) uut
   (
      .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .conv_config(conv_config),
      .conv_clk_en(conv_clk_en), .conv_sample(conv_sample), .raw_valid(raw_valid),
      .raw_result(raw_result), .ram_write(ram_write), .irq_request(irq_request)
   );

   sample_ram ram (.ref_clk(ref_clk), .ram_write(ram_write));

   //*************************************************************
   // Checking and bus tasks
   //*************************************************************

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // The address phase is held until hreadyout is seen high, then the data phase likewise.
   task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {16'h0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
   endtask

   task rd(input logic [15:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask

   // The sum is kept wide so that the clamp and the saturation flag are judged unwrapped.
   function automatic logic [15:0] corr(input logic [15:0] raw);
      longint p;
      p = ((longint'($signed(raw)) + longint'($signed(offs))) * longint'(gain)) >>> 15;
      sat_exp = (p > 32767) || (p < -32768);
      if (p > 32767)
         return 16'h7fff;
      if (p < -32768)
         return 16'h8000;
      return p[15:0];
   endfunction

   task smp(input logic [15:0] v, input logic w, input logic [12:0] a);
      if (w)
         wq.push_back({a, corr(v)});
      raw_valid <= 1'b1;
      raw_result <= v;
      @(posedge ref_clk);
      raw_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task pin(input logic seen_sel, input logic exp);
      @(posedge ref_clk);
      #1;
      chk({31'h0, seen_sel ? irq_request : conv_sample}, {31'h0, exp});
   endtask

   task pulses(input int n);
      int k;
      k = 0;
      repeat (60) @(posedge ref_clk) k += conv_clk_en;
      chk(k, n);
   endtask

   //*************************************************************
   // Monitor, clock, timeout and main sequence
   //*************************************************************

   always @(posedge ref_clk)
   begin
      if (rd_phase && rq.size() > 0)
      begin
         chk(hrdata, rq.pop_front());
         chk({30'h0, hreadyout, hresp}, 32'h2);
      end
      rd_phase = hsel && htrans[1] && !hwrite;
      if (ram_write.write_en === 1'b1)
         chk({ram_write.addr, ram_write.data}, wq.size() > 0 ? wq.pop_front() : '1);
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         results();
      end
   end

   initial
   begin
      ref_clk = 0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata, raw_valid, raw_result, rd_phase} = '0;
      hsize = 3'b010;
      hready = 1'b1;
      reset = 1'b1;
      void'($urandom(63));
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      for (i = 0; i < 11; i++)
         rd(ofs[i], rst[i]);
      bus(1'b1, 16'h0004, 32'hffff_ffff);
      rd(16'h0004, 0);
      smp(16'h0100, 1'b0, 0);
      rd(`OFS_DMA_STATE, 32'h2);
      bus(1'b1, `OFS_EVENT_ENABLES, 32'h10);
      pin(1'b1, 1'b1);
      bus(1'b1, `OFS_EVENT_FLAGS, 32'h1);
      rd(`OFS_EVENT_FLAGS, 32'h10);
      bus(1'b1, `OFS_EVENT_FLAGS, 32'h11);
      pin(1'b1, 1'b0);
      bus(1'b1, `OFS_EVENT_ENABLES, 32'h0e);
      smp(16'h0200, 1'b0, 0);
      pin(1'b1, 1'b0);
      rd(`OFS_EVENT_ENABLES, 32'h0e);
      bus(1'b1, `OFS_DMA_CONTROL, 32'h10);
      rd(`OFS_DMA_CONTROL, 0);
      rd(`OFS_DMA_STATE, 0);
      offs = 16'($urandom_range(0, 511)) - 16'd256;
      gain = 16'($urandom_range(16'h4000, 16'hc000));
      bus(1'b1, `OFS_OFFSET, {16'h0, offs});
      bus(1'b1, `OFS_GAIN, {16'h0, gain});
      bus(1'b1, `OFS_BUF_START, 32'h0101);
      rd(`OFS_BUF_START, 32'h2000_0100);
      bus(1'b1, `OFS_BUF_LENGTH, 32'h4);
      bus(1'b1, `OFS_EVENT_FLAGS, 32'h1f);
      bus(1'b1, `OFS_DMA_CONTROL, 32'h1);
      // The DMA takes the start bit one cycle after the write, so it reads 0 once that cycle has passed.
      @(posedge ref_clk);
      rd(`OFS_DMA_CONTROL, 0);
      rd(`OFS_DMA_STATE, 32'h1);
      for (i = 0; i < 5; i++)
      begin
         smp(16'($urandom_range(0, 16'h3fff)), i < 4, 13'h100 + 13'(2 * i));
         if (i == 0)
            rd(`OFS_NEXT_ADDR, 32'h2000_0102);
         if (i == 1)
            rd(`OFS_EVENT_FLAGS, 32'h2);
      end
      rd(`OFS_EVENT_FLAGS, 32'h16);
      rd(`OFS_DMA_COUNT, 32'h4);
      rd(`OFS_DMA_STATE, 32'h2);
      // Wrap mode with near-double gain drives both clamp limits.
      bus(1'b1, `OFS_DMA_CONTROL, 32'h10);
      bus(1'b1, `OFS_BUF_LENGTH, 32'h2);
      bus(1'b1, `OFS_EVENT_FLAGS, 32'h1f);
      gain = 16'hffff;
      bus(1'b1, `OFS_GAIN, 32'hffff);
      bus(1'b1, `OFS_DMA_CONTROL, 32'h3);
      @(posedge ref_clk);
      smp(16'h7000, 1'b1, 13'h100);
      smp(16'h9000, 1'b1, 13'h102);
      smp(16'h0010, 1'b1, 13'h100);
      rd(`OFS_EVENT_FLAGS, 32'h0e);
      rd(`OFS_DMA_STATE, 32'h1);
      bus(1'b1, `OFS_CONFIG, 32'h1);
      pin(1'b0, 1'b0);
      for (i = 0; i < 30 && conv_sample !== 1'b1; i++)
         @(posedge ref_clk);
      chk(conv_sample, 1'b1);
      pulses(20);
      cfg = {16'h0, 3'($urandom), 2'($urandom), 4'($urandom_range(0, 5)), 4'h9, 3'b101};
      bus(1'b1, `OFS_CONFIG, cfg);
      rd(`OFS_CONFIG, cfg);
      chk({16'h0, conv_config}, cfg);
      pulses(3);
      bus(1'b1, `OFS_CONFIG, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk(conv_sample, 1'b0);
      repeat (3) @(posedge ref_clk);
      chk(rq.size() + wq.size(), 0);
      results();
   end

endmodule

`default_nettype wire

// ===== design/adc_ctrl.sv
// Converter control, offset and gain correction and sample DMA with event flags.
// Assumes one AHB-Lite master, a raw converter result strobed on ref_clk, and a RAM that
// accepts one halfword write per cycle without stalling.
//
// Functional notes
// - Period field picks sample time of 32 times two to the field clocks.
// - Range bits 12 and 11: 1 enables input buffer for high range.
// - Positive selector: six pins, ground, half reference, reference, half regulator.
// - Negative selector same codes; ground and half regulator banned in high range.
// - Clock select bit chooses 6 MHz at 0 and 1 MHz at 1; the code divides by 3 at 0, giving about 6.67 MHz.
// - Enable bit 1 runs conversions back to back until written 0.
// - First conversion after start lasts twice sample clocks plus 21 us.
// - Config write while running makes the conversion in progress twice as long.
// - Signed 16-bit offset is added to each raw result before gain.
// - Unsigned gain with binary point between bits 15 and 14; 0x8000 unity.
// - DMA reset bit resets the DMA and clears itself.
// - Wrap bit 0 stops DMA when full; 1 restarts from buffer start.
// - Start bit 1 starts DMA; cleared when DMA starts or resets.
// - Overrun status sets when a result is ready with DMA inactive.
// - Active status reads 1 while the DMA runs.
// - Buffer start is 13 bits with the lowest bit held at zero.
// - Buffer length counts 16-bit results, not bytes.
// - Next address field bits 12 to 1 shows next halfword written.
// - Count field shows results written into the buffer so far.
// - Flags: overrun bit 4, saturation 3, full 2, half full 1.
// - Enable register has one enable per flag at the same positions.
// - Writing one to a flag clears it; zero leaves it.
// - Only enabled flags request the interrupt; otherwise software polls.
// - Saturation flag sets when gain result leaves signed 16-bit range.
// - Full sets on last location write; half on last of first half.
//
// Design decision made here: register access over AHB-Lite.
`include "adc_ctrl_map.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES
)
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output config_s          conv_config,
   output logic             conv_clk_en,
   output logic             conv_sample,
   input  wire logic        raw_valid,
   input  wire logic [15:0] raw_result,
   output ram_write_s       ram_write,
   output logic             irq_request
);

   // ***********************************************
   // Bus slave
   // ***********************************************
   logic        wr_pend_ff, nxt_wr_pend;
   logic [15:0] wr_addr_ff, nxt_wr_addr;
   logic        bus_take;
   logic        wr_now;

   assign bus_take  = hsel && hready && htrans[1];
   assign wr_now    = wr_pend_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_comb
   begin
      nxt_wr_pend = bus_take && hwrite;
      nxt_wr_addr = bus_take ? haddr[15:0] : wr_addr_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 16'h0000;
      end
      else
      begin
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
      end
   end

   function automatic logic hit(input logic [15:0] ofs);
      hit = wr_now && (wr_addr_ff == ofs);
   endfunction

   // ***********************************************
   // Registers
   // ***********************************************
   logic [15:0] cfg_ff, nxt_cfg;
   logic [15:0] offset_ff, nxt_offset;
   logic [15:0] gain_ff, nxt_gain;
   logic        wrap_ff, nxt_wrap;
   logic        start_ff, nxt_start;
   logic [12:0] buf_start_ff, nxt_buf_start;
   logic [11:0] buf_len_ff, nxt_buf_len;
   logic [4:1]  enables_ff, nxt_enables;
   logic        cfg_touched;
   logic        dma_reset_cmd;

   assign cfg_touched   = hit(`OFS_CONFIG) && conv_config.enable;
   assign dma_reset_cmd = hit(`OFS_DMA_CONTROL) && hwdata[`DMA_RESET_BIT];
   assign conv_config   = config_s'(cfg_ff);

   logic dma_go;

   always_comb
   begin
      nxt_cfg       = hit(`OFS_CONFIG) ? hwdata[15:0] : cfg_ff;
      nxt_offset    = hit(`OFS_OFFSET) ? hwdata[15:0] : offset_ff;
      nxt_gain      = hit(`OFS_GAIN) ? hwdata[15:0] : gain_ff;
      nxt_wrap      = hit(`OFS_DMA_CONTROL) ? hwdata[`DMA_WRAP_BIT] : wrap_ff;
      nxt_start     = start_ff;
      if (hit(`OFS_DMA_CONTROL) && hwdata[`DMA_START_BIT])
         nxt_start = 1'b1;
      if (dma_go || dma_reset_cmd)
         nxt_start = 1'b0;
      nxt_buf_start = hit(`OFS_BUF_START) ? {hwdata[12:1], 1'b0} : buf_start_ff;
      nxt_buf_len   = hit(`OFS_BUF_LENGTH) ? hwdata[11:0] : buf_len_ff;
      nxt_enables   = hit(`OFS_EVENT_ENABLES) ? hwdata[4:1] : enables_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cfg_ff       <= `CFG_RESET;
         offset_ff    <= 16'h0000;
         gain_ff      <= `GAIN_RESET;
         wrap_ff      <= 1'b0;
         start_ff     <= 1'b0;
         buf_start_ff <= 13'h0000;
         buf_len_ff   <= 12'h000;
         enables_ff   <= 4'h0;
      end
      else
      begin
         cfg_ff       <= nxt_cfg;
         offset_ff    <= nxt_offset;
         gain_ff      <= nxt_gain;
         wrap_ff      <= nxt_wrap;
         start_ff     <= nxt_start;
         buf_start_ff <= nxt_buf_start;
         buf_len_ff   <= nxt_buf_len;
         enables_ff   <= nxt_enables;
      end
   end

   // ***********************************************
   // Converter clock and conversion timing
   // ***********************************************
   // The fast rate is approximate: 20 MHz does not divide to 6 MHz, so it uses divide by 3.
   localparam logic [4:0] FAST_DIV = 5'(`REF_CLK_HZ / `FAST_CONV_HZ);
   localparam logic [4:0] SLOW_DIV = 5'(`REF_CLK_HZ / `SLOW_CONV_HZ);

   logic [4:0]  div_ff, nxt_div;
   logic [4:0]  div_top;

   assign div_top     = conv_config.slow_clock_sel ? SLOW_DIV : FAST_DIV;
   assign conv_clk_en = (div_ff == 5'd0);

   always_comb
   begin
      nxt_div = conv_clk_en ? 5'(div_top - 5'd1) : 5'(div_ff - 5'd1);
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         div_ff <= 5'd0;
      else
         div_ff <= nxt_div;
   end

   conv_state_e state_ff, nxt_state;
   logic [13:0] clk_cnt_ff, nxt_clk_cnt;
   logic [15:0] start_cnt_ff, nxt_start_cnt;
   logic        double_ff, nxt_double;
   logic [13:0] sample_len;

   assign sample_len  = 14'(`BASE_SAMPLE_CLKS) << conv_config.period;
   assign conv_sample = (state_ff == CONV_SAMPLE);

   always_comb
   begin
      nxt_state     = state_ff;
      nxt_clk_cnt   = clk_cnt_ff;
      nxt_start_cnt = start_cnt_ff;
      nxt_double    = double_ff || cfg_touched;
      unique case (state_ff)
         CONV_IDLE:
         begin
            if (conv_config.enable)
            begin
               nxt_state     = CONV_STARTUP;
               nxt_start_cnt = 16'(STARTUP_CYCLES);
               nxt_double    = 1'b1;
               nxt_clk_cnt   = 14'd0;
            end
         end
         CONV_STARTUP:
         begin
            if (start_cnt_ff <= 16'd1)
               nxt_state = CONV_SAMPLE;
            else
               nxt_start_cnt = start_cnt_ff - 16'd1;
         end
         CONV_SAMPLE:
         begin
            if (conv_clk_en)
            begin
               if (clk_cnt_ff + 14'd1 >= (double_ff ? 14'(sample_len << 1) : sample_len))
               begin
                  nxt_clk_cnt = 14'd0;
                  nxt_double  = cfg_touched;
               end
               else
                  nxt_clk_cnt = clk_cnt_ff + 14'd1;
            end
         end
      endcase
      if (!conv_config.enable)
      begin
         nxt_state = CONV_IDLE;
         nxt_double = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_ff     <= CONV_IDLE;
         clk_cnt_ff   <= 14'd0;
         start_cnt_ff <= 16'd0;
         double_ff    <= 1'b0;
      end
      else
      begin
         state_ff     <= nxt_state;
         clk_cnt_ff   <= nxt_clk_cnt;
         start_cnt_ff <= nxt_start_cnt;
         double_ff    <= nxt_double;
      end
   end

   // ***********************************************
   // Offset and gain correction
   // ***********************************************
   logic signed [16:0] off_sum;
   logic signed [34:0] product;
   logic signed [20:0] scaled;
   logic               sat_now;
   logic [15:0]        corrected;

   always_comb
   begin
      off_sum = 17'(signed'(raw_result)) + 17'(signed'(offset_ff));
      product = 35'(off_sum) * 35'(signed'({1'b0, gain_ff}));
      scaled  = 21'(product >>> 15);
      sat_now = raw_valid && (scaled > 21'sd32767 || scaled < -21'sd32768);
      if (scaled > 21'sd32767)
         corrected = 16'h7fff;
      else if (scaled < -21'sd32768)
         corrected = 16'h8000;
      else
         corrected = scaled[15:0];
   end

   // ***********************************************
   // Sample DMA
   // ***********************************************
   logic        active_ff, nxt_active;
   logic        overrun_ff, nxt_overrun;
   logic [11:0] count_ff, nxt_count;
   logic [12:1] cur_ff, nxt_cur;
   logic        last_loc, half_loc;
   ram_write_s  ram_ff, nxt_ram;

   assign dma_go    = start_ff && !active_ff;
   assign last_loc  = (count_ff + 12'd1 == buf_len_ff);
   assign half_loc  = (count_ff + 12'd1 == (buf_len_ff >> 1));
   assign ram_write = ram_ff;

   always_comb
   begin
      nxt_active  = active_ff;
      nxt_overrun = overrun_ff || (raw_valid && !active_ff);
      nxt_count   = count_ff;
      nxt_cur     = cur_ff;
      nxt_ram     = '{write_en: 1'b0, addr: ram_ff.addr, data: ram_ff.data};
      if (dma_go)
      begin
         nxt_active = 1'b1;
         nxt_count  = 12'd0;
         nxt_cur    = buf_start_ff[12:1];
      end
      else if (active_ff && raw_valid)
      begin
         nxt_ram = '{write_en: 1'b1, addr: {cur_ff, 1'b0}, data: corrected};
         if (last_loc)
         begin
            nxt_count  = wrap_ff ? 12'd0 : buf_len_ff;
            nxt_cur    = buf_start_ff[12:1];
            nxt_active = wrap_ff;
         end
         else
         begin
            nxt_count = count_ff + 12'd1;
            nxt_cur   = cur_ff + 12'd1;
         end
      end
      if (dma_reset_cmd)
      begin
         nxt_active  = 1'b0;
         nxt_overrun = 1'b0;
         nxt_count   = 12'd0;
         nxt_cur     = buf_start_ff[12:1];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         active_ff  <= 1'b0;
         overrun_ff <= 1'b0;
         count_ff   <= 12'd0;
         cur_ff     <= 12'd0;
         ram_ff     <= '0;
      end
      else
      begin
         active_ff  <= nxt_active;
         overrun_ff <= nxt_overrun;
         count_ff   <= nxt_count;
         cur_ff     <= nxt_cur;
         ram_ff     <= nxt_ram;
      end
   end

   // ***********************************************
   // Event flags
   // ***********************************************
   logic [4:1] flags_ff, nxt_flags;
   logic [4:1] evt_set;
   logic [4:1] evt_clr;

   always_comb
   begin
      evt_set = '0;
      evt_set[`EVT_OVERRUN]    = raw_valid && !active_ff;
      evt_set[`EVT_SATURATION] = sat_now;
      evt_set[`EVT_FULL]       = active_ff && raw_valid && last_loc;
      evt_set[`EVT_HALF]       = active_ff && raw_valid && half_loc;
      evt_clr   = hit(`OFS_EVENT_FLAGS) ? hwdata[4:1] : 4'h0;
      // Set wins over clear so an event in the clearing cycle is never lost.
      nxt_flags = (flags_ff & ~evt_clr) | evt_set;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         flags_ff <= 4'h0;
      else
         flags_ff <= nxt_flags;
   end

   assign irq_request = |(flags_ff & enables_ff);

   // ***********************************************
   // Read data
   // ***********************************************
   logic [31:0] rdata_ff, nxt_rdata;

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (bus_take && !hwrite)
      begin
         unique case (haddr[15:0])
            `OFS_DMA_COUNT:     nxt_rdata = {20'h0_0000, count_ff};
            `OFS_EVENT_FLAGS:   nxt_rdata = {27'h000_0000, flags_ff, 1'b0};
            `OFS_EVENT_ENABLES: nxt_rdata = {27'h000_0000, enables_ff, 1'b0};
            `OFS_CONFIG:        nxt_rdata = {16'h0000, cfg_ff};
            `OFS_OFFSET:        nxt_rdata = {16'h0000, offset_ff};
            `OFS_GAIN:          nxt_rdata = {16'h0000, gain_ff};
            `OFS_DMA_CONTROL:   nxt_rdata = {30'h0000_0000, wrap_ff, start_ff};
            `OFS_DMA_STATE:     nxt_rdata = {30'h0000_0000, overrun_ff, active_ff};
            `OFS_BUF_START:     nxt_rdata = `BUF_START_RESET | {19'h0_0000, buf_start_ff};
            `OFS_BUF_LENGTH:    nxt_rdata = {20'h0_0000, buf_len_ff};
            `OFS_NEXT_ADDR:     nxt_rdata = `BUF_START_RESET | {19'h0_0000, cur_ff, 1'b0};
            default:            nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         rdata_ff <= 32'h0000_0000;
      else
         rdata_ff <= nxt_rdata;
   end

   assign hrdata = rdata_ff;

   // ***********************************************
   // Assertions
   // ***********************************************
   property p_irq_follows;
      @(posedge ref_clk) disable iff (reset) irq_request == |(flags_ff & enables_ff);
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

   property p_flag_set_wins;
      @(posedge ref_clk) disable iff (reset)
         evt_set[`EVT_FULL] |=> flags_ff[`EVT_FULL];
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) else $error("full flag lost");

   property p_w1c;
      @(posedge ref_clk) disable iff (reset)
         (evt_clr[`EVT_HALF] && !evt_set[`EVT_HALF]) |=> !flags_ff[`EVT_HALF];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");

   property p_overrun;
      @(posedge ref_clk) disable iff (reset)
         (raw_valid && !active_ff && !dma_reset_cmd) |=> overrun_ff && flags_ff[`EVT_OVERRUN];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_dma_reset;
      @(posedge ref_clk) disable iff (reset)
         dma_reset_cmd |=> !active_ff && !overrun_ff && !start_ff && count_ff == 12'd0;
   endproperty
   a_dma_reset: assert property (p_dma_reset) else $error("dma reset failed");

   property p_start_clears;
      @(posedge ref_clk) disable iff (reset)
         (dma_go && !dma_reset_cmd) |=> active_ff && !start_ff;
   endproperty
   a_start_clears: assert property (p_start_clears) else $error("start not taken");

   property p_clamp;
      @(posedge ref_clk) disable iff (reset)
         (scaled > 21'sd32767) |-> corrected == 16'h7fff;
   endproperty
   a_clamp: assert property (p_clamp) else $error("no clamp");

   property p_linear_stop;
      @(posedge ref_clk) disable iff (reset)
         (active_ff && raw_valid && last_loc && !wrap_ff && !dma_reset_cmd) |=> !active_ff;
   endproperty
   a_linear_stop: assert property (p_linear_stop) else $error("linear did not stop");

   property p_stop;
      @(posedge ref_clk) disable iff (reset) !conv_config.enable |=> state_ff == CONV_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("conversions did not stop");

   c_full: cover property (@(posedge ref_clk) disable iff (reset) evt_set[`EVT_FULL]);
   c_sat: cover property (@(posedge ref_clk) disable iff (reset) sat_now);
   c_wrap: cover property (@(posedge ref_clk) disable iff (reset)
      active_ff && raw_valid && last_loc && wrap_ff);

endmodule

`default_nettype wire

// ===== design/adc_ctrl_map.svh
// Register map, field positions, reset values and timing counts of the converter control block.
// Assumes a 20 MHz ref_clk and AHB-Lite word access.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define OFS_DMA_COUNT     16'h0000
`define OFS_EVENT_FLAGS   16'ha810
`define OFS_EVENT_ENABLES 16'ha850
`define OFS_CONFIG        16'hd004
`define OFS_OFFSET        16'hd008
`define OFS_GAIN          16'hd00c
`define OFS_DMA_CONTROL   16'hd010
`define OFS_DMA_STATE     16'hd014
`define OFS_BUF_START     16'hd018
`define OFS_BUF_LENGTH    16'hd01c
`define OFS_NEXT_ADDR     16'hd020

`define CFG_RESET         16'h1800
`define GAIN_RESET        16'h8000
`define BUF_START_RESET   32'h2000_0000

`define CFG_PERIOD_HI     15
`define CFG_PERIOD_LO     13
`define CFG_POS_RANGE     12
`define CFG_NEG_RANGE     11
`define CFG_POS_SEL_HI    10
`define CFG_POS_SEL_LO    7
`define CFG_NEG_SEL_HI    6
`define CFG_NEG_SEL_LO    3
`define CFG_SLOW_CLK      2
`define CFG_ENABLE        0

`define DMA_RESET_BIT     4
`define DMA_WRAP_BIT      1
`define DMA_START_BIT     0

`define EVT_OVERRUN       4
`define EVT_SATURATION    3
`define EVT_FULL          2
`define EVT_HALF          1

`define REF_CLK_HZ        20000000
`define FAST_CONV_HZ      6000000
`define SLOW_CONV_HZ      1000000
`define STARTUP_US        21
`define STARTUP_CYCLES    ((`STARTUP_US * (`REF_CLK_HZ / 1000000)))
`define BASE_SAMPLE_CLKS  32

`endif

// ===== design/adc_ctrl_pkg.sv
// Types shared by the converter control block.
// Assumes adc_ctrl_map.svh supplies the numeric constants.
package adc_ctrl_pkg;

   typedef enum logic [1:0]
   {
      CONV_IDLE    = 2'b00,
      CONV_STARTUP = 2'b01,
      CONV_SAMPLE  = 2'b11
   } conv_state_e;

   typedef struct packed
   {
      logic [2:0] period;
      logic       pos_high_range;
      logic       neg_high_range;
      logic [3:0] pos_input_sel;
      logic [3:0] neg_input_sel;
      logic       slow_clock_sel;
      logic       reserved_zero;
      logic       enable;
   } config_s;

   typedef struct packed
   {
      logic        write_en;
      logic [12:0] addr;
      logic [15:0] data;
   } ram_write_s;

endpackage
